// *** pkg/can_irq_map.svh ***
// Purpose: register offsets, field positions and reset values
// Assumes: included by the package and by the design modules
// Notes:   offsets are byte addresses on a 32-bit APB
`ifndef CAN_IRQ_MAP_SVH
`define CAN_IRQ_MAP_SVH

// register byte offsets
`define OFS_PIN_CTRL   12'h000
`define OFS_FLAGS      12'h004
`define OFS_ENABLES    12'h008
`define OFS_PRIOS      12'h00c

// pin control fields
`define BIT_DRIVE_HIGH 5
`define BIT_CAPTURE    4
`define PIN_CTRL_MASK  8'h30

// flag / enable / priority positions
`define BIT_INVALID    7
`define BIT_WAKE       6
`define BIT_ERROR      5
`define BIT_TX_TWO     4
`define BIT_TX_ONE     3
`define BIT_TX_ZERO    2
`define BIT_RX_ONE     1
`define BIT_RX_ZERO    0

// reset values
`define RST_PIN_CTRL   8'h00
`define RST_FLAGS      8'h00
`define RST_ENABLES    8'h00
`define RST_PRIOS      8'hff

// implemented bits per mode
`define MASK_MODE0     8'hff
`define MASK_MODE1     8'hf2
`define MASK_MODE2     8'hf3
`define LEVEL_BITS     8'h12

`endif

// *** pkg/can_irq_pkg.sv ***
// Purpose: types and helpers of the can interrupt and pin block
// Assumes: map header holds every number
// Notes:   mode code 3 is treated like the fifo mode
package can_irq_pkg;
`include "can_irq_map.svh"

  typedef enum logic [1:0] {MODE_LEGACY, MODE_ENHANCED, MODE_FIFO} can_mode_t;

  typedef enum logic [2:0] {SEL_PIN, SEL_FLAGS, SEL_EN, SEL_PRIO, SEL_NONE} reg_sel_t;

  // mode code to mode
  function automatic can_mode_t decode_mode(input logic [1:0] code);
    can_mode_t m;
    m = MODE_FIFO;
    if (code == 2'h0)
      m = MODE_LEGACY;
    else if (code == 2'h1)
      m = MODE_ENHANCED;
    return m;
  endfunction : decode_mode

  // bits that exist in flag, enable and priority registers
  function automatic logic [7:0] mode_mask(input can_mode_t m);
    logic [7:0] k;
    k = `MASK_MODE2;
    if (m == MODE_LEGACY)
      k = `MASK_MODE0;
    else if (m == MODE_ENHANCED)
      k = `MASK_MODE1;
    return k;
  endfunction : mode_mask

  // apb address decode
  function automatic reg_sel_t reg_select(input logic [11:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == `OFS_PIN_CTRL)
      s = SEL_PIN;
    else if (a == `OFS_FLAGS)
      s = SEL_FLAGS;
    else if (a == `OFS_ENABLES)
      s = SEL_EN;
    else if (a == `OFS_PRIOS)
      s = SEL_PRIO;
    return s;
  endfunction : reg_select

endpackage : can_irq_pkg

// *** src/can_pin_drive.sv ***
// Purpose: transmit pin driver and capture input select
// Assumes: tx_bit low is dominant
// Notes:   outputs registered, one cycle behind their inputs
`timescale 1ns/1ps
module can_pin_drive
  import can_irq_pkg::*;
(
  input  wire logic clk,          // system clock
  input  wire logic rst,          // async reset, high
  input  wire logic drive_high,   // drive supply when recessive
  input  wire logic capture_en,   // message signal to capture
  input  wire logic tx_bit,       // bit from the protocol engine
  input  wire logic rx_msg,       // message receive signal
  input  wire logic cap_pin,      // general capture pin input
  output logic      pin_out,      // transmit pin level
  output logic      pin_oe_n,     // low while pin is driven
  output logic      capture_in    // to the capture unit
);

  // transmit pin: dominant low, recessive high or released
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out  <= 1'b1;
      pin_oe_n <= 1'b1;
    end
    else
    begin
      pin_out  <= tx_bit;
      pin_oe_n <= tx_bit & ~drive_high;
    end
  end

  // capture source select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      capture_in <= 1'b0;
    else
      capture_in <= capture_en ? rx_msg : cap_pin;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_recessive_driven: assert property (tx_bit && drive_high |=> !pin_oe_n && pin_out)
    else $error("recessive bit not driven high");
  a_recessive_float: assert property (tx_bit && !drive_high |=> pin_oe_n)
    else $error("recessive bit not released");
  a_capture_source: assert property (##1 capture_in == $past(capture_en ? rx_msg : cap_pin))
    else $error("capture source wrong");

endmodule : can_pin_drive

// *** src/irq_priority_split.sv ***
// Purpose: split active requests into high and low lines
// Assumes: req already gated by flags and enables
// Notes:   one cycle from request to line
`timescale 1ns/1ps
module irq_priority_split
  import can_irq_pkg::*;
(
  input  wire logic       clk,      // system clock
  input  wire logic       rst,      // async reset, high
  input  wire logic [7:0] req,      // per-source requests
  input  wire logic [7:0] prio,     // 1 high, 0 low
  output logic            irq_high, // high priority request
  output logic            irq_low   // low priority request
);

  // registered request lines
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_high <= 1'b0;
      irq_low  <= 1'b0;
    end
    else
    begin
      irq_high <= |(req & prio);
      irq_low  <= |(req & ~prio);
    end
  end

endmodule : irq_priority_split

// *** src/can_irq_pin_ctrl.sv ***
// Purpose: can interrupt flags, enables, priorities and pin control
// Assumes: apb master per protocol, event inputs one-cycle pulses
// Notes:   mode comes from the controller as a two-bit code
//
// Contract
// - drive-high bit drives recessive transmit high
// - capture bit routes message signal to capture
// - invalid message sets flag bit 7
// - bus activity sets flag bit 6
// - any module error sets flag bit 5
// - mode 0: tx buffer 2 done sets bit 4
// - modes 1,2: bit 4 shows any tx ready
// - mode 0: tx buffers 1,0 set bits 3,2
// - modes 1,2: bits 3,2 held zero
// - mode 0: rx buffers 1,0 set bits 1,0
// - modes 1,2: bit 1 shows any rx full
// - mode 2 watermark sets bit 0; mode 1 zero
// - enables 7..5 gate events, reset zero
// - mode 0: separate enables bits 4..0, reset zero
// - modes 1,2: enable 4 gates all tx
// - modes 1,2: enable 1 gates all rx
// - mode 2 enable 0 gates watermark; mode 1 zero
// - priority bit per source, reset one
// - per-buffer tx enable needs master enable too
`timescale 1ns/1ps
`include "can_irq_map.svh"
module can_irq_pin_ctrl
  import can_irq_pkg::*;
(
  input  wire logic        SYS_CLK,         // system clock, 100 MHz
  input  wire logic        RST,             // async reset, high
  input  wire logic        PSEL,            // apb select
  input  wire logic        PENABLE,         // apb access phase
  input  wire logic        PWRITE,          // apb write
  input  wire logic [11:0] PADDR,           // apb byte address
  input  wire logic [31:0] PWDATA,          // apb write data
  output logic      [31:0] PRDATA,          // apb read data
  output logic             PREADY,          // apb ready
  output logic             PSLVERR,         // apb error, unmapped
  input  wire logic [1:0]  CAN_MODE,        // 0 legacy, 1 enhanced, 2 fifo
  input  wire logic        INVALID_MSG_EVT, // invalid message pulse
  input  wire logic        WAKE_EVT,        // bus activity pulse
  input  wire logic        ERROR_EVT,       // any module error pulse
  input  wire logic [2:0]  TX_DONE_EVT,     // tx buffer 2..0 done pulses
  input  wire logic [1:0]  RX_DONE_EVT,     // rx buffer 1..0 new message
  input  wire logic        FIFO_WM_EVT,     // fifo high watermark pulse
  input  wire logic [2:0]  TX_READY,        // tx buffers ready, level
  input  wire logic [2:0]  TX_BUF_IE,       // per tx buffer enables
  input  wire logic [7:0]  RX_FULL,         // rx buffers full, level
  input  wire logic [7:0]  RX_BUF_IE,       // per rx buffer enables
  input  wire logic        TX_BIT,          // protocol bit, low dominant
  input  wire logic        RX_MSG_SIGNAL,   // message receive signal
  input  wire logic        CAPTURE_PIN_IN,  // general capture pin
  output logic             TX_PIN_OUT,      // transmit pin level
  output logic             TX_PIN_OE_N,     // low while pin driven
  output logic             CAPTURE_IN,      // capture unit input
  output logic             IRQ_HIGH,        // high priority request
  output logic             IRQ_LOW          // low priority request
);

  logic [7:0]  pin_ctrl;
  logic [7:0]  flags;
  logic [7:0]  enables;
  logic [7:0]  prios;
  logic [7:0]  mask;
  logic [7:0]  store_mask;
  logic [7:0]  level_vec;
  logic [7:0]  set_vec;
  logic [7:0]  flag_view;
  logic [7:0]  req;
  logic [7:0]  next_flags;
  logic [7:0]  read_val;
  logic        setup;
  logic        done;
  logic        wr_pin;
  logic        wr_flags;
  logic        wr_en;
  logic        wr_prio;
  can_mode_t   mode;
  reg_sel_t    sel;

  // mode and implemented bits
  assign mode = decode_mode(CAN_MODE);
  assign mask = mode_mask(mode);

  // apb phases and write strobes
  assign sel      = reg_select(PADDR);
  assign setup    = PSEL & ~PENABLE;
  assign done     = PSEL & PENABLE & PREADY;
  assign wr_pin   = done & PWRITE & (sel == SEL_PIN);
  assign wr_flags = done & PWRITE & (sel == SEL_FLAGS);
  assign wr_en    = done & PWRITE & (sel == SEL_EN);
  assign wr_prio  = done & PWRITE & (sel == SEL_PRIO);

  // ready rises for the one access cycle after each setup
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      PREADY <= 1'b0;
    else
      PREADY <= setup;
  end

  // read value, bits above the register read as zero
  always_comb
  begin
    read_val = 8'h00;
    unique case (sel)
      SEL_PIN:   read_val = pin_ctrl;
      SEL_FLAGS: read_val = flag_view;
      SEL_EN:    read_val = enables;
      SEL_PRIO:  read_val = prios;
      SEL_NONE:  read_val = 8'h00;
    endcase
  end

  // read data and error are sampled in the setup cycle
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (setup)
    begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, read_val};
      PSLVERR <= (sel == SEL_NONE);
    end
  end

  // pin control, spare bits never stored
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      pin_ctrl <= `RST_PIN_CTRL;
    else if (wr_pin)
      pin_ctrl <= PWDATA[7:0] & `PIN_CTRL_MASK;
  end

  // hardware set sources per mode
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[`BIT_INVALID] = INVALID_MSG_EVT;
    set_vec[`BIT_WAKE]    = WAKE_EVT;
    set_vec[`BIT_ERROR]   = ERROR_EVT;
    unique case (mode)
      MODE_LEGACY:
      begin
        set_vec[`BIT_TX_TWO]  = TX_DONE_EVT[2];
        set_vec[`BIT_TX_ONE]  = TX_DONE_EVT[1];
        set_vec[`BIT_TX_ZERO] = TX_DONE_EVT[0];
        set_vec[`BIT_RX_ONE]  = RX_DONE_EVT[1];
        set_vec[`BIT_RX_ZERO] = RX_DONE_EVT[0];
      end
      MODE_ENHANCED:
        set_vec[`BIT_RX_ZERO] = 1'b0;
      MODE_FIFO:
        set_vec[`BIT_RX_ZERO] = FIFO_WM_EVT;
    endcase
  end

  // any-buffer bits follow buffer state outside legacy mode
  always_comb
  begin
    level_vec = 8'h00;
    if (mode != MODE_LEGACY)
    begin
      level_vec[`BIT_TX_TWO] = |TX_READY;
      level_vec[`BIT_RX_ONE] = |RX_FULL;
    end
  end

  // stored bits exclude level bits and unimplemented bits
  assign store_mask = (mode == MODE_LEGACY) ? mask : (mask & ~`LEVEL_BITS);

  // set wins over a software clear on the same edge
  assign next_flags = ((wr_flags ? PWDATA[7:0] : flags) | set_vec) & store_mask;

  // flag register
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      flags <= `RST_FLAGS;
    else
      flags <= next_flags;
  end

  // read view, a stored bit left from another mode is hidden at once
  assign flag_view = (flags & store_mask) | level_vec;

  // enable register, masked per mode
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      enables <= `RST_ENABLES;
    else
      enables <= (wr_en ? PWDATA[7:0] : enables) & mask;
  end

  // priority register, masked per mode
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      prios <= `RST_PRIOS;
    else
      prios <= (wr_prio ? PWDATA[7:0] : prios) & mask;
  end

  // per-source requests, any-buffer bits gated per buffer
  always_comb
  begin
    req = flag_view & enables;
    if (mode != MODE_LEGACY)
    begin
      req[`BIT_TX_TWO] = req[`BIT_TX_TWO] & |(TX_READY & TX_BUF_IE);
      req[`BIT_RX_ONE] = req[`BIT_RX_ONE] & |(RX_FULL & RX_BUF_IE);
    end
  end

  // priority split onto the two request lines
  irq_priority_split u_split (
    .clk      (SYS_CLK),
    .rst      (RST),
    .req      (req),
    .prio     (prios),
    .irq_high (IRQ_HIGH),
    .irq_low  (IRQ_LOW)
  );

  // transmit pin and capture path
  can_pin_drive u_pin (
    .clk        (SYS_CLK),
    .rst        (RST),
    .drive_high (pin_ctrl[`BIT_DRIVE_HIGH]),
    .capture_en (pin_ctrl[`BIT_CAPTURE]),
    .tx_bit     (TX_BIT),
    .rx_msg     (RX_MSG_SIGNAL),
    .cap_pin    (CAPTURE_PIN_IN),
    .pin_out    (TX_PIN_OUT),
    .pin_oe_n   (TX_PIN_OE_N),
    .capture_in (CAPTURE_IN)
  );

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // event flags
  a_invalid_sets: assert property
    (INVALID_MSG_EVT |=> flags[`BIT_INVALID])
    else $error("invalid message flag not set");
  a_wake_sets: assert property
    (WAKE_EVT |=> flags[`BIT_WAKE])
    else $error("wake flag not set");
  a_error_sets: assert property
    (ERROR_EVT |=> flags[`BIT_ERROR])
    else $error("error flag not set");
  a_tx_two_legacy: assert property
    (mode == MODE_LEGACY && TX_DONE_EVT[2] |=> flags[`BIT_TX_TWO])
    else $error("tx buffer two flag not set");
  a_tx_any_level: assert property
    (mode != MODE_LEGACY |-> flag_view[`BIT_TX_TWO] == (|TX_READY))
    else $error("any tx flag not following buffers");
  a_tx_low_legacy: assert property
    (mode == MODE_LEGACY && (|TX_DONE_EVT[1:0])
     |=> (flags[3:2] & $past(TX_DONE_EVT[1:0])) == $past(TX_DONE_EVT[1:0]))
    else $error("tx buffer one or zero flag not set");
  a_tx_bits_zero: assert property
    (mode != MODE_LEGACY |=>
     flags[3:2] == 2'b00 && enables[3:2] == 2'b00 && prios[3:2] == 2'b00)
    else $error("bits three and two not held zero");
  a_rx_legacy: assert property
    (mode == MODE_LEGACY && (|RX_DONE_EVT)
     |=> (flags[1:0] & $past(RX_DONE_EVT)) == $past(RX_DONE_EVT))
    else $error("rx buffer one or zero flag not set");
  a_rx_any_level: assert property
    (mode != MODE_LEGACY |-> flag_view[`BIT_RX_ONE] == (|RX_FULL))
    else $error("any rx flag not following buffers");
  a_watermark_sets: assert property
    (mode == MODE_FIFO && FIFO_WM_EVT |=> flags[`BIT_RX_ZERO])
    else $error("watermark flag not set");
  a_bit0_mode1: assert property
    (mode == MODE_ENHANCED |=> !flags[0] && !enables[0] && !prios[0])
    else $error("bit zero not zero in mode one");

  // enables and gating
  a_enable_write: assert property
    (wr_en && mode == MODE_LEGACY |=> enables == $past(PWDATA[7:0]))
    else $error("enable write lost");
  a_tx_master_gate: assert property
    (mode != MODE_LEGACY &&
     (!enables[`BIT_TX_TWO] || !(|(TX_READY & TX_BUF_IE))) |-> !req[`BIT_TX_TWO])
    else $error("tx request passed a closed gate");
  a_rx_master_gate: assert property
    (mode != MODE_LEGACY && !enables[`BIT_RX_ONE] |-> !req[`BIT_RX_ONE])
    else $error("rx request passed a closed gate");

  // request lines and flag clearing
  a_high_request: assert property
    (|(req & prios) |=> IRQ_HIGH)
    else $error("high request missing");
  a_low_request: assert property
    (|(req & ~prios) |=> IRQ_LOW)
    else $error("low request missing");
  a_no_request: assert property
    (req == 8'h00 |=> !IRQ_HIGH && !IRQ_LOW)
    else $error("request without cause");
  a_flag_sticky: assert property
    (flags[`BIT_ERROR] && !wr_flags |=> flags[`BIT_ERROR])
    else $error("flag dropped without a write");
  a_legacy_clear: assert property
    (wr_flags && mode == MODE_LEGACY && set_vec == 8'h00 |=> flags == $past(PWDATA[7:0]))
    else $error("flag write not stored");
  a_set_beats_clear: assert property
    (wr_flags && PWDATA[`BIT_WAKE] == 1'b0 && WAKE_EVT |=> flags[`BIT_WAKE])
    else $error("event lost under clear");

  // pin control and bus answer
  a_pin_spare_zero: assert property
    (wr_pin |=> pin_ctrl == ($past(PWDATA[7:0]) & 8'h30))
    else $error("pin control spare bits stored");
  a_pin_read_zero: assert property
    (done && !PWRITE && sel == SEL_PIN
     |-> PRDATA[7:6] == 2'b00 && PRDATA[3:0] == 4'h0)
    else $error("pin control spare bits read back");
  a_apb_one_wait: assert property
    (setup |=> PREADY ##1 !PREADY)
    else $error("apb ready timing wrong");
  a_apb_error: assert property
    (done |-> PSLVERR == (sel == SEL_NONE))
    else $error("apb error does not match the address");

  // main scenarios
  c_high_irq: cover property (IRQ_HIGH);
  c_low_irq: cover property (IRQ_LOW);
  c_fifo_flag: cover property (mode == MODE_FIFO && FIFO_WM_EVT ##1 flags[0]);
  c_bad_addr: cover property (done && PSLVERR);
  c_set_under_clear: cover property (wr_flags && WAKE_EVT);

endmodule : can_irq_pin_ctrl

// *** test/can_far_model.sv ***
// Purpose: far side of the block, the transceiver on the transmit pin
// Assumes: pin_oe_n high means the pin is released
// Notes:   a released line shows no stale level, it toggles every cycle
`timescale 1ns/1ps
module can_far_model
(
  input  wire logic clk,       // system clock
  input  wire logic rst,       // async reset, high
  input  wire logic pin_out,   // pin level from the block
  input  wire logic pin_oe_n,  // low while the block drives
  output logic      bus_level  // line level seen by the receiver
);
  // the line follows a driven pin; released, it changes every cycle so no
  // held value can pass for a driven one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus_level <= 1'b1;
    else if (pin_oe_n)
      bus_level <= ~bus_level;
    else
      bus_level <= pin_out;
  end
endmodule : can_far_model

// *** test/tb_top.sv ***
// Purpose: self-checking bench of the can interrupt and pin block
// Assumes: apb answer comes within eight access cycles
// Notes:   apb is sampled at the rising edge, other outputs at the falling edge
`timescale 1ns/1ps
`include "can_irq_map.svh"
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [1:0]  mode    = 2'h0;
  logic [7:0]  ev      = 8'h00;
  logic        wm      = 1'b0;
  logic [2:0]  tx_rdy  = 3'h0;
  logic [2:0]  tx_ie   = 3'h0;
  logic [7:0]  rx_full = 8'h00;
  logic [7:0]  rx_ie   = 8'h00;
  logic        tx_bit  = 1'b1;
  logic        cap_pin = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_out;
  logic        pin_oe_n;
  logic        cap_in;
  logic        irq_h;
  logic        irq_l;
  logic        bus_lvl;
  logic [31:0] rd;
  logic        er;
  int          err_count       = 0;
  int          samples_checked = 0;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  can_irq_pin_ctrl i_dut (
    .SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CAN_MODE(mode), .INVALID_MSG_EVT(ev[7]), .WAKE_EVT(ev[6]),
    .ERROR_EVT(ev[5]), .TX_DONE_EVT(ev[4:2]), .RX_DONE_EVT(ev[1:0]),
    .FIFO_WM_EVT(wm), .TX_READY(tx_rdy), .TX_BUF_IE(tx_ie), .RX_FULL(rx_full),
    .RX_BUF_IE(rx_ie), .TX_BIT(tx_bit), .RX_MSG_SIGNAL(bus_lvl),
    .CAPTURE_PIN_IN(cap_pin), .TX_PIN_OUT(pin_out), .TX_PIN_OE_N(pin_oe_n),
    .CAPTURE_IN(cap_in), .IRQ_HIGH(irq_h), .IRQ_LOW(irq_l));

  can_far_model i_far (.clk(sys_clk), .rst(rst), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .bus_level(bus_lvl));

  task automatic report_and_stop;
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1)
      check(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rdchk

  // let registered outputs and the far model follow
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task automatic irq_is(input logic h, input logic l);
    check({30'h0, irq_h, irq_l}, {30'h0, h, l});
  endtask : irq_is

  task automatic t_reset;
    rdchk(`OFS_PIN_CTRL, 8'h00);
    rdchk(`OFS_FLAGS, 8'h00);
    rdchk(`OFS_ENABLES, 8'h00);
    rdchk(`OFS_PRIOS, 8'hff);
    apb(1'b0, 12'h010, 8'h00);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, 12'h005, 8'h00);
    check({31'h0, er}, 32'h1);
  endtask : t_reset

  task automatic t_pins;
    wr(`OFS_PIN_CTRL, 8'hff);
    rdchk(`OFS_PIN_CTRL, 8'h30);
    @(posedge sys_clk);
    cap_pin <= 1'b1;
    settle;
    check({30'h0, pin_oe_n, pin_out}, 32'h1);
    check({31'h0, bus_lvl}, 32'h1);
    @(posedge sys_clk);
    tx_bit <= 1'b0;
    settle;
    check({30'h0, pin_oe_n, pin_out}, 32'h0);
    check({31'h0, cap_in}, 32'h0);
    wr(`OFS_PIN_CTRL, 8'h20);
    settle;
    check({31'h0, cap_in}, 32'h1);
    wr(`OFS_PIN_CTRL, 8'h00);
    @(posedge sys_clk);
    tx_bit <= 1'b1;
    settle;
    check({31'h0, pin_oe_n}, 32'h1);
  endtask : t_pins

  // each mode 0 source in turn: sticky flag, enable gate, high priority for even sources, low for odd
  task automatic t_mode0;
    for (int i = 0; i < 8; i++)
    begin
      wr(`OFS_ENABLES, 8'h00);
      wr(`OFS_PRIOS, i[0] ? 8'h00 : 8'hff);
      @(posedge sys_clk);
      ev <= 8'h01 << i;
      @(posedge sys_clk);
      ev <= 8'h00;
      rdchk(`OFS_FLAGS, 8'h01 << i);
      settle;
      irq_is(1'b0, 1'b0);
      wr(`OFS_ENABLES, 8'h01 << i);
      settle;
      irq_is(~i[0], i[0]);
      wr(`OFS_FLAGS, 8'h00);
      settle;
      irq_is(1'b0, 1'b0);
    end
    // a wake event on the clearing edge must survive the clear
    wr(`OFS_FLAGS, 8'h20);
    fork
      wr(`OFS_FLAGS, 8'h00);
      begin
        repeat (2) @(posedge sys_clk);
        ev <= 8'h40;
        @(posedge sys_clk);
        ev <= 8'h00;
      end
    join
    rdchk(`OFS_FLAGS, 8'h40);
    wr(`OFS_FLAGS, 8'h00);
  endtask : t_mode0

  // buffer modes: masked bits, level flags and the two-level gating
  task automatic t_modes;
    logic [7:0] k;
    for (int m = 1; m < 3; m++)
    begin
      k = (m == 2) ? 8'hf3 : 8'hf2;
      @(posedge sys_clk);
      mode    <= m[1:0];
      tx_rdy  <= 3'h2;
      rx_full <= 8'h04;
      tx_ie   <= 3'h0;
      rx_ie   <= 8'h00;
      wr(`OFS_FLAGS, 8'hff);
      rdchk(`OFS_FLAGS, k);
      wr(`OFS_ENABLES, 8'hff);
      rdchk(`OFS_ENABLES, k);
      wr(`OFS_PRIOS, 8'hff);
      rdchk(`OFS_PRIOS, k);
      wr(`OFS_FLAGS, 8'h00);
      rdchk(`OFS_FLAGS, 8'h12);
      settle;
      irq_is(1'b0, 1'b0);
      @(posedge sys_clk);
      tx_ie <= 3'h2;
      settle;
      irq_is(1'b1, 1'b0);
      wr(`OFS_ENABLES, k & 8'hef);
      settle;
      irq_is(1'b0, 1'b0);
      @(posedge sys_clk);
      tx_rdy <= 3'h0;
      rx_ie  <= 8'h04;
      settle;
      irq_is(1'b1, 1'b0);
      wr(`OFS_ENABLES, k & 8'hfd);
      settle;
      irq_is(1'b0, 1'b0);
      @(posedge sys_clk);
      rx_full <= 8'h00;
      wm      <= 1'b1;
      @(posedge sys_clk);
      wm <= 1'b0;
      rdchk(`OFS_FLAGS, (m == 2) ? 8'h01 : 8'h00);
      settle;
      irq_is(m == 2, 1'b0);
      wr(`OFS_FLAGS, 8'h00);
    end
  endtask : t_modes

  // main sequence, reset held for four cycles
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_pins;
    t_mode0;
    t_modes;
    report_and_stop;
  end

  // watchdog far beyond the expected run length
  initial
  begin
    #100us;
    err_count++;
    report_and_stop;
  end
endmodule : tb_top
